//--- cive_defs.vh
// cive_defs.vh: register map, field positions, reset values and code points
// of the six-channel current input value encoder.
// assumes: included by bare name from the encoder and its value store.
`ifndef CIVE_DEFS_VH
`define CIVE_DEFS_VH

// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define CIVE_CHANNELS 6
`define CIVE_RAW_W 17
`define CIVE_VAL_W 16
`define CIVE_ADDR_W 8

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define CIVE_ADDR_CONFIG 8'h00
`define CIVE_ADDR_EVENTS 8'h04
`define CIVE_ADDR_MASK 8'h08
`define CIVE_ADDR_STATE 8'h0C
`define CIVE_ADDR_VALUE0 8'h10
`define CIVE_ADDR_VALUE5 8'h24

// ----------------------------------------------------------------------
// field positions (each field is six bits, one per channel)
// ----------------------------------------------------------------------
`define CIVE_CFG_RANGE_LSB 0
`define CIVE_CFG_WB_LSB 8
`define CIVE_CFG_PROTO_LSB 16
`define CIVE_EV_WB_LSB 0
`define CIVE_EV_UF_LSB 8
`define CIVE_EV_OF_LSB 16
`define CIVE_ST_FAULT_LSB 0
`define CIVE_ST_PROTO_LSB 8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CIVE_CONFIG_RST 32'h0000_0000
`define CIVE_MASK_RST 32'h0000_0000
`define CIVE_EVENTS_RST 32'h0000_0000

// ----------------------------------------------------------------------
// raw current code: lsb 578.7 nA, 4 mA = 6912, 20 mA = 34560
// ----------------------------------------------------------------------
`define CIVE_RAW_4MA 18'h0_1B00
`define CIVE_SCALE_0_20 17'h0_6667
`define CIVE_RAW_WB_0_20 17'h0_0300
`define CIVE_RAW_WB_4_20 17'h0_184D

// ----------------------------------------------------------------------
// encoded value limits and codes (18-bit signed working width)
// ----------------------------------------------------------------------
`define CIVE_OVER_LIM 18'h0_7EFF
`define CIVE_UNDER_LIM 18'h3_E800
`define CIVE_CODE_HIGH 16'h7FFF
`define CIVE_CODE_LOW 16'h8000

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define CIVE_RESP_OKAY 2'b00
`define CIVE_RESP_SLVERR 2'b10

`endif

//--- cive_value_store.v
// cive_value_store.v: eight-word store of encoded process values.
// assumes: one write port from the encoder, one read port from the bus,
// both on aclk; read data is registered, one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
`include "cive_defs.vh"

module cive_value_store (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// write side
	input wire wr_en,
	input wire [2:0] wr_addr,
	input wire [15:0] wr_data,
	// read side
	input wire [2:0] rd_addr,
	output reg [15:0] rd_data
);

	reg [15:0] mem [0:7];
	integer i;

	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < 8; i = i + 1) begin
				mem[i] <= 16'h0000;
			end
			rd_data <= 16'h0000;
		end else begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end

endmodule
`default_nettype wire

//--- cive_encoder.v
// cive_encoder.v: encodes digitised current readings of six channels into
// signed 16-bit process values, with range, wire-break and limit handling.
// assumes: samples arrive from same-clock converter logic; protocol running
// flags come from the modem side and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "cive_defs.vh"

// Notes on behaviour
// R01: six independent channels, each with its own value and diagnostics.
// R02: values are 16-bit two's complement, sign in bit 15.
// R03: zero-based 20 mA range always checks wire break, whatever the config.
// R04: zero-based range: below 0.4444 mA gives wire-break code 7FFF.
// R05: 4-20 mA wire-break check is per channel; enabled it skips underflow.
// R06: 4-20 mA with wire-break check: below 3.6 mA gives 7FFF.
// R07: 4-20 mA without wire-break check: below 0.4444 mA gives 8000.
// R08: one controller variant substitutes zero for the limit codes.
// R09: the other controller variant outputs its programmed fail-safe value.
// R10: field protocol only on 4-20 mA channels, never on zero-based range.
// R11: protocol indicator lit only when enabled and actually running.
// R12: range start encodes 0, 20 mA 27648, overrange 32511, underrange -6144.
// R13: above overrange gives 32767; 4-20 mA without wire-break check below underrange gives -32768.
module cive_encoder (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// converter samples
	input wire sample_valid,
	input wire [2:0] sample_channel,
	input wire [16:0] sample_raw,
	// field protocol modem
	input wire [5:0] protocol_running,
	output wire [5:0] protocol_allowed,
	// indicators
	output reg [5:0] channel_fault_indicator,
	output wire [5:0] channel_protocol_status_indicator,
	output wire group_fault_indicator,
	output wire irq,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	reg [31:0] config_reg;
	reg [31:0] events;
	reg [31:0] mask;
	reg [5:0] run_meta;
	reg [5:0] run_sync;

	wire [5:0] range_4_20 = config_reg[`CIVE_CFG_RANGE_LSB +: 6];
	wire [5:0] wb_enable = config_reg[`CIVE_CFG_WB_LSB +: 6];
	wire [5:0] proto_enable = config_reg[`CIVE_CFG_PROTO_LSB +: 6];

	// ------------------------------------------------------------------
	// field protocol gating
	// ------------------------------------------------------------------
	assign protocol_allowed = proto_enable & range_4_20; // R10
	assign channel_protocol_status_indicator = protocol_allowed & run_sync; // R11

	always @(posedge aclk) begin
		if (!aresetn) begin
			run_meta <= 6'h00;
			run_sync <= 6'h00;
		end else begin
			run_meta <= protocol_running;
			run_sync <= run_meta;
		end
	end

	// ------------------------------------------------------------------
	// scaling of the sample
	// ------------------------------------------------------------------
	// 0-20 mA: times 0.8 by a fixed multiply; 4-20 mA: remove 4 mA offset
	wire [32:0] product = {16'h0000, sample_raw} * {16'h0000, `CIVE_SCALE_0_20};
	wire [17:0] scaled_0_20 = product[32:15];
	wire [17:0] scaled_4_20 = {1'b0, sample_raw} - `CIVE_RAW_4MA;
	wire ch_valid = (sample_channel < 3'd6);
	wire sel_4_20 = ch_valid ? range_4_20[sample_channel] : 1'b0;
	wire sel_wb = ch_valid ? wb_enable[sample_channel] : 1'b0;
	wire [17:0] scaled = sel_4_20 ? scaled_4_20 : scaled_0_20; // R12

	reg [15:0] next_value;
	reg hit_wb;
	reg hit_uf;
	reg hit_of;

	always @* begin
		hit_wb = 1'b0;
		hit_uf = 1'b0;
		hit_of = 1'b0;
		next_value = scaled[15:0]; // R02
		if (!sel_4_20) begin
			// wire-break check here ignores the config bit
			if (sample_raw < `CIVE_RAW_WB_0_20) begin // R03
				hit_wb = 1'b1;
				next_value = `CIVE_CODE_HIGH; // R04
			end
		end else if (sel_wb) begin
			// underflow check not made while wire-break check is on
			if (sample_raw < `CIVE_RAW_WB_4_20) begin // R05
				hit_wb = 1'b1;
				next_value = `CIVE_CODE_HIGH; // R06
			end
		end else if ($signed(scaled) < $signed(`CIVE_UNDER_LIM)) begin
			hit_uf = 1'b1;
			next_value = `CIVE_CODE_LOW; // R07 R13
		end
		if (!hit_wb && !hit_uf && ($signed(scaled) > $signed(`CIVE_OVER_LIM))) begin
			hit_of = 1'b1;
			next_value = `CIVE_CODE_HIGH; // R13
		end
	end

	wire take = sample_valid & ch_valid;

	// ------------------------------------------------------------------
	// per-channel diagnostics
	// ------------------------------------------------------------------
	wire [31:0] ev_set;
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_chan
			localparam [2:0] CH_ID = g;
			wire mine = take & (sample_channel == CH_ID);
			assign ev_set[`CIVE_EV_WB_LSB + g] = mine & hit_wb;
			assign ev_set[`CIVE_EV_UF_LSB + g] = mine & hit_uf;
			assign ev_set[`CIVE_EV_OF_LSB + g] = mine & hit_of;
			always @(posedge aclk) begin
				if (!aresetn) begin
					channel_fault_indicator[g] <= 1'b0;
				end else if (mine) begin
					channel_fault_indicator[g] <= hit_wb | hit_uf | hit_of; // R01
				end
			end
		end
	endgenerate
	assign ev_set[7:6] = 2'b00;
	assign ev_set[15:14] = 2'b00;
	assign ev_set[31:22] = 10'h000;

	assign group_fault_indicator = |channel_fault_indicator;
	assign irq = |(events & mask);

	// ------------------------------------------------------------------
	// value store
	// ------------------------------------------------------------------
	reg [2:0] rd_index;
	wire [2:0] rd_pick;
	wire [15:0] stored_value;

	cive_value_store u_store (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(take),
		.wr_addr(sample_channel),
		.wr_data(next_value),
		.rd_addr(rd_pick),
		.rd_data(stored_value)
	);

	// ------------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------------
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;

	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire wr_config = do_write && (aw_addr[7:2] == `CIVE_ADDR_CONFIG >> 2);
	wire wr_events = do_write && (aw_addr[7:2] == `CIVE_ADDR_EVENTS >> 2);
	wire wr_mask = do_write && (aw_addr[7:2] == `CIVE_ADDR_MASK >> 2);
	wire [31:0] ev_clear = wr_events ? (w_data & byte_mask) : 32'h0000_0000;
	// only the six-bit fields exist in the writable registers
	wire [31:0] field_bits = 32'h003F_3F3F;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CIVE_RESP_OKAY;
			config_reg <= `CIVE_CONFIG_RST;
			mask <= `CIVE_MASK_RST;
			events <= `CIVE_EVENTS_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_config || wr_events || wr_mask) ?
					`CIVE_RESP_OKAY : `CIVE_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_config) begin
				config_reg <= ((config_reg & ~byte_mask) | (w_data & byte_mask)) & field_bits;
			end
			if (wr_mask) begin
				mask <= ((mask & ~byte_mask) | (w_data & byte_mask)) & field_bits;
			end
			// a new event in the clearing cycle survives the clear
			events <= (events & ~ev_clear) | ev_set;
		end
	end

	// ------------------------------------------------------------------
	// axi4-lite read path
	// ------------------------------------------------------------------
	localparam RD_IDLE = 2'd0;
	localparam RD_FETCH = 2'd1;
	localparam RD_RESP = 2'd2;

	reg [1:0] rd_state;
	reg [7:0] ar_addr;

	assign s_axi_arready = (rd_state == RD_IDLE);
	// store output is registered: the index must go in at the address edge
	assign rd_pick = (rd_state == RD_IDLE) ? s_axi_araddr[4:2] - 3'd4 : rd_index;

	wire [5:0] ar_word = ar_addr[7:2];
	wire is_value = (ar_word >= (`CIVE_ADDR_VALUE0 >> 2)) && (ar_word <= (`CIVE_ADDR_VALUE5 >> 2));
	wire [7:0] value_ofs = ar_addr - `CIVE_ADDR_VALUE0;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= RD_IDLE;
			ar_addr <= 8'h00;
			rd_index <= 3'd0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CIVE_RESP_OKAY;
		end else begin
			case (rd_state)
				RD_IDLE: begin
					if (s_axi_arvalid) begin
						ar_addr <= s_axi_araddr;
						rd_index <= rd_pick;
						rd_state <= RD_FETCH;
					end
				end
				RD_FETCH: begin
					s_axi_rvalid <= 1'b1;
					s_axi_rresp <= `CIVE_RESP_OKAY;
					rd_state <= RD_RESP;
					if (is_value) begin
						// sign extended so software sees a signed word
						s_axi_rdata <= {{16{stored_value[15]}}, stored_value}; // R02
					end else if (ar_word == (`CIVE_ADDR_CONFIG >> 2)) begin
						s_axi_rdata <= config_reg;
					end else if (ar_word == (`CIVE_ADDR_EVENTS >> 2)) begin
						s_axi_rdata <= events;
					end else if (ar_word == (`CIVE_ADDR_MASK >> 2)) begin
						s_axi_rdata <= mask;
					end else if (ar_word == (`CIVE_ADDR_STATE >> 2)) begin
						s_axi_rdata <= {16'h0000, 2'b00, channel_protocol_status_indicator,
							2'b00, channel_fault_indicator};
					end else begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `CIVE_RESP_SLVERR;
					end
				end
				RD_RESP: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rd_state <= RD_IDLE;
					end
				end
				default: begin
					rd_state <= RD_IDLE;
					s_axi_rvalid <= 1'b0;
				end
			endcase
		end
	end

	// index is only meaningful for value words; unused offset bits drop here
	wire unused_ofs = |{value_ofs[7:5], value_ofs[1:0]};

endmodule
`default_nettype wire

//--- cive_checker.sv
// cive_checker.sv: concurrent checks on the encoder's ports.
// assumes: bound to every cive_encoder instance; one aclk domain.
`timescale 1ns/1ps
`default_nettype none
module cive_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// samples and protocol
	input wire logic sample_valid,
	input wire logic [2:0] sample_channel,
	input wire logic [5:0] protocol_running,
	input wire logic [5:0] protocol_allowed,
	// indicators
	input wire logic [5:0] channel_fault_indicator,
	input wire logic [5:0] channel_protocol_status_indicator,
	input wire logic group_fault_indicator,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence s_take;
		sample_valid && sample_channel < 3'd6;
	endsequence
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_group_fault_or: assert property (
		group_fault_indicator == |channel_fault_indicator) else $error("group fault mismatch");
	a_fault_idle_hold: assert property (
		!(sample_valid && sample_channel < 3'd6) |=> $stable(channel_fault_indicator))
		else $error("fault indicator moved without a sample");
	a_fault_own_channel: assert property (s_take |=>
		((channel_fault_indicator ^ $past(channel_fault_indicator))
		& ~(6'd1 << $past(sample_channel))) == 6'h00) else $error("foreign fault bit moved");
	a_proto_needs_allowed: assert property (
		(channel_protocol_status_indicator & ~protocol_allowed) == 6'h00)
		else $error("protocol status lit while not allowed");
	a_proto_needs_running: assert property (
		(channel_protocol_status_indicator & ~$past(protocol_running, 2)) == 6'h00)
		else $error("protocol status lit while not running");
	a_read_answer_time: assert property (s_ar_take |=> !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read answer not two cycles after address");
	a_read_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped or changed");
	a_write_answer_time: assert property (s_wr_take |=> ##1 s_axi_bvalid)
		else $error("write response late");
endmodule

bind cive_encoder cive_checker u_chk (.*);
`default_nettype wire

//--- cive_ctrl_model.sv
// cive_ctrl_model.sv: safety controller side, builds the process image.
// assumes: fed with the low half of each value word read over the bus.
`timescale 1ns/1ps
`default_nettype none
module cive_ctrl_model (
	// value from the device
	input wire logic [15:0] value,
	// controller variant and its programmed replacement
	input wire logic substitute_zero,
	input wire logic [15:0] fail_safe,
	// image handed to the safety program
	output logic [15:0] input_process_image
);
	// the wire-break and overflow codes are alike, so both are replaced
	wire limit_code = (value == 16'h7FFF) || (value == 16'h8000);
	assign input_process_image = !limit_code ? value :
		substitute_zero ? 16'h0000 : fail_safe;
endmodule
`default_nettype wire

//--- testbench.sv
// testbench.sv: self-checking bench for the current input value encoder.
// assumes: design, checker and controller model compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic aclk = 0;
	logic aresetn = 0;
	logic sample_valid = 0;
	logic [2:0] sample_channel = 0;
	logic [16:0] sample_raw = 0;
	logic [5:0] protocol_running = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	wire [5:0] protocol_allowed, channel_fault_indicator, channel_protocol_status_indicator;
	wire group_fault_indicator, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] image;
	logic substitute_zero = 0;
	logic [15:0] fail_safe = 16'h1234;
	logic [31:0] rq;
	logic [1:0] rs;
	int errors = 0, n_checks = 0, cyc = 0;

	cive_encoder u_dut (.*);
	cive_ctrl_model u_ctrl (.value(rq[15:0]), .substitute_zero(substitute_zero),
		.fail_safe(fail_safe), .input_process_image(image));

	initial forever #10 aclk = ~aclk;

	// ------------------------------------------------------------
	// bus and sample tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, da, dw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		da = 0;
		dw = 0;
		while (!(da && dw)) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			da = da || ta;
			dw = dw || tw;
		end
		s_axi_bready <= 1;
		do begin
			@(negedge aclk);
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
		end while (!tb);
		s_axi_bready <= 0;
	endtask

	// rready comes late on purpose so the answer has to stand
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end while (!t);
		s_axi_arvalid <= 0;
		repeat (3) @(posedge aclk);
		s_axi_rready <= 1;
		do begin
			@(negedge aclk);
			t = s_axi_rvalid;
			rq = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
		end while (!t);
		s_axi_rready <= 0;
		chk(rq, e);
	endtask

	task automatic val(input logic [2:0] c, input logic [16:0] r, input logic [31:0] e);
		sample_channel <= c;
		sample_raw <= r;
		sample_valid <= 1;
		@(posedge aclk);
		sample_valid <= 0;
		rd(8'h10 + {3'b000, c, 2'b00}, e);
	endtask

	task automatic summarize;
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors++;
			summarize;
		end
	end

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		for (int a = 0; a < 44; a += 4)
			rd(a[7:0], 32'h0);
		chk(rs, 32'h2);
		wr(8'h28, 32'hFFFF_FFFF);
		chk(rs, 32'h2);
		// ch0 zero-based with check bit, ch1 4-20 plain, ch2 4-20 with check
		wr(8'h00, 32'h0003_0506);
		rd(8'h00, 32'h0003_0506);
		val(0, 17'd767, 32'h7FFF);
		val(0, 17'd768, 32'd614);
		chk(image, 32'd614);
		val(0, 17'd0, 32'h7FFF);
		val(0, 17'd34560, 32'd27648);
		val(1, 17'd6912, 32'h0);
		val(1, 17'd768, 32'hFFFF_E800);
		val(1, 17'd767, 32'hFFFF_8000);
		chk(image, 32'h1234);
		val(1, 17'd39423, 32'd32511);
		val(1, 17'd39424, 32'h7FFF);
		val(2, 17'd6221, 32'hFFFF_FD4D);
		val(2, 17'd0, 32'h7FFF);
		val(2, 17'd6220, 32'h7FFF);
		val(3, 17'd767, 32'h7FFF);
		val(3, 17'd768, 32'd614);
		// channel 6 does not exist: the sample must leave everything alone
		sample_channel <= 3'd6;
		sample_raw <= 17'd0;
		sample_valid <= 1;
		@(posedge aclk);
		sample_valid <= 0;
		rd(8'h10, 32'd27648);
		rd(8'h0C, 32'h0000_0006);
		chk(group_fault_indicator, 32'h1);
		rd(8'h04, 32'h0002_020D);
		chk(irq, 32'h0);
		wr(8'h08, 32'h0000_0200);
		chk(irq, 32'h1);
		wr(8'h04, 32'h0000_020D);
		rd(8'h04, 32'h0002_0000);
		chk(irq, 32'h0);
		protocol_running <= 6'h3F;
		repeat (3) @(posedge aclk);
		chk(protocol_allowed, 32'h02);
		chk(channel_protocol_status_indicator, 32'h02);
		protocol_running <= 6'h00;
		repeat (3) @(posedge aclk);
		chk(channel_protocol_status_indicator, 32'h0);
		substitute_zero <= 1;
		rd(8'h14, 32'h7FFF);
		chk(image, 32'h0);
		summarize;
	end
endmodule
`default_nettype wire
